// [dce_pkg.sv]
/*
 constants for the dma channel engine: register indices, control field
 positions, item width codes and reset values.
 assumes a single core clock and an axi4-lite register bus.
*/
package dce_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [31:0] IDX_OFS = 32'h5000_361e;
    localparam logic [31:0] SRC_LO_OFS = 32'h5000_3620;
    localparam logic [31:0] SRC_HI_OFS = 32'h5000_3622;
    localparam logic [31:0] DST_LO_OFS = 32'h5000_3624;
    localparam logic [31:0] DST_HI_OFS = 32'h5000_3626;
    localparam logic [31:0] INTP_OFS = 32'h5000_3628;
    localparam logic [31:0] LEN_OFS = 32'h5000_362a;
    localparam logic [31:0] CTRL_OFS = 32'h5000_362c;
    // control fields
    localparam int CB_SENSE = 13;
    localparam int CB_FILL = 12;
    localparam int CB_YIELD = 11;
    localparam int CB_CIRC = 7;
    localparam int CB_SRC_STEP = 6;
    localparam int CB_DST_STEP = 5;
    localparam int CB_WFR = 4;
    localparam int CB_IRQ_EN = 3;
    localparam int CB_WIDTH_LO = 1;
    localparam int CB_RUN = 0;
    localparam logic [15:0] CTRL_WMASK = 16'h3fff;
    // item width codes
    localparam logic [1:0] W_BYTE = 2'h0;
    localparam logic [1:0] W_HALF = 2'h1;
    localparam logic [1:0] W_WORD = 2'h2;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_WAIT = 5'b00010,
        ST_READ = 5'b00100,
        ST_WRITE = 5'b01000,
        ST_GAP = 5'b10000
    } dce_state_e;
endpackage

// [dce_channel.sv]
/*
 one dma channel: axi4-lite register slave and a single-item bus master.
 assumes the system bus answers each request with a one-cycle ack and
 read data valid in that cycle, and a synchronous peripheral request.
*/
`timescale 1ns/1ps
module dce_channel #(
    parameter int AW = 16
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // axi4-lite write
    input wire logic [AW-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // axi4-lite read
    input wire logic [AW-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // system bus master
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [1:0] o_mem_width,
    output logic [31:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    output logic o_bus_lock,
    // peripheral and interrupt
    input wire logic i_periph_req,
    output logic o_irq
);
    dce_pkg::dce_state_e state_reg;
    logic [15:0] idx_reg, src_lo_reg, src_hi_reg, dst_lo_reg, dst_hi_reg;
    logic [15:0] intp_reg, len_reg, ctrl_reg;
    logic [AW-1:0] aw_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic [31:0] data_reg;
    logic req_prev_reg, edge_pend_reg;
    logic do_write, item_done, last_item, relaunch, clear_run, trigger, consume;
    logic [31:0] rd_next;
    logic rd_hit;

    function automatic logic hit(input logic [AW-1:0] a, input logic [31:0] ofs);
        hit = (a[AW-1:2] == ofs[AW-3:0]);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d, input logic [3:0] s);
        merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [31:0] step_addr(input logic [31:0] base,
                                              input logic [15:0] idx,
                                              input logic [1:0] w, input logic on);
        logic [31:0] off;
        off = {16'h0000, idx};
        if (!on) begin
            step_addr = base;
        end else if (w == dce_pkg::W_WORD) begin
            step_addr = base + {off[29:0], 2'b00};
        end else if (w == dce_pkg::W_HALF) begin
            step_addr = base + {off[30:0], 1'b0};
        end else begin
            step_addr = base + off;
        end
    endfunction

    wire c_sense = ctrl_reg[dce_pkg::CB_SENSE];
    wire c_fill = ctrl_reg[dce_pkg::CB_FILL];
    wire c_yield = ctrl_reg[dce_pkg::CB_YIELD];
    wire c_circ = ctrl_reg[dce_pkg::CB_CIRC];
    wire c_wfr = ctrl_reg[dce_pkg::CB_WFR];
    wire c_irq_en = ctrl_reg[dce_pkg::CB_IRQ_EN];
    wire c_run = ctrl_reg[dce_pkg::CB_RUN];
    wire [1:0] c_width = ctrl_reg[dce_pkg::CB_WIDTH_LO +: 2];
    wire [31:0] src_addr = step_addr({src_hi_reg, src_lo_reg}, idx_reg, c_width,
                                     ctrl_reg[dce_pkg::CB_SRC_STEP]);
    wire [31:0] dst_addr = step_addr({dst_hi_reg, dst_lo_reg}, idx_reg, c_width,
                                     ctrl_reg[dce_pkg::CB_DST_STEP]);

    assign do_write = !o_awready && !o_wready && !o_bvalid;
    assign item_done = (state_reg == dce_pkg::ST_WRITE) && o_mem_req && i_mem_ack;
    assign last_item = (idx_reg == len_reg);
    assign relaunch = c_circ && c_wfr;
    assign clear_run = item_done && last_item && !relaunch;
    assign trigger = c_sense ? edge_pend_reg : i_periph_req;
    assign consume = (state_reg == dce_pkg::ST_WAIT) && c_run && trigger;

    // axi write channels
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= dce_pkg::RESP_OKAY;
            aw_q <= '0;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_q <= i_awaddr;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                wd_q <= i_wdata;
                ws_q <= i_wstrb;
                o_wready <= 1'b0;
            end
            if (do_write) begin
                o_bvalid <= 1'b1;
                o_bresp <= (hit(aw_q, dce_pkg::SRC_LO_OFS) || hit(aw_q, dce_pkg::SRC_HI_OFS)
                    || hit(aw_q, dce_pkg::DST_LO_OFS) || hit(aw_q, dce_pkg::DST_HI_OFS)
                    || hit(aw_q, dce_pkg::INTP_OFS) || hit(aw_q, dce_pkg::LEN_OFS)
                    || hit(aw_q, dce_pkg::CTRL_OFS) || hit(aw_q, dce_pkg::IDX_OFS))
                    ? dce_pkg::RESP_OKAY : dce_pkg::RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    // configuration registers
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            src_lo_reg <= dce_pkg::REG_RST;
            src_hi_reg <= dce_pkg::REG_RST;
            dst_lo_reg <= dce_pkg::REG_RST;
            dst_hi_reg <= dce_pkg::REG_RST;
            intp_reg <= dce_pkg::REG_RST;
            len_reg <= dce_pkg::REG_RST;
        end else if (do_write) begin
            if (hit(aw_q, dce_pkg::SRC_LO_OFS)) src_lo_reg <= merge(src_lo_reg, wd_q, ws_q);
            if (hit(aw_q, dce_pkg::SRC_HI_OFS)) src_hi_reg <= merge(src_hi_reg, wd_q, ws_q);
            if (hit(aw_q, dce_pkg::DST_LO_OFS)) dst_lo_reg <= merge(dst_lo_reg, wd_q, ws_q);
            if (hit(aw_q, dce_pkg::DST_HI_OFS)) dst_hi_reg <= merge(dst_hi_reg, wd_q, ws_q);
            if (hit(aw_q, dce_pkg::INTP_OFS)) intp_reg <= merge(intp_reg, wd_q, ws_q);
            if (hit(aw_q, dce_pkg::LEN_OFS)) len_reg <= merge(len_reg, wd_q, ws_q);
        end
    end

    // control register; software write wins over completion clear
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= dce_pkg::REG_RST;
        end else if (do_write && hit(aw_q, dce_pkg::CTRL_OFS)) begin
            ctrl_reg <= merge(ctrl_reg, wd_q, ws_q) & dce_pkg::CTRL_WMASK;
        end else if (clear_run) begin
            ctrl_reg[dce_pkg::CB_RUN] <= 1'b0;
        end
    end

    // read mux
    always_comb begin
        rd_hit = 1'b1;
        rd_next = 32'h0000_0000;
        if (hit(i_araddr, dce_pkg::IDX_OFS)) rd_next[15:0] = idx_reg;
        else if (hit(i_araddr, dce_pkg::SRC_LO_OFS)) rd_next[15:0] = src_lo_reg;
        else if (hit(i_araddr, dce_pkg::SRC_HI_OFS)) rd_next[15:0] = src_hi_reg;
        else if (hit(i_araddr, dce_pkg::DST_LO_OFS)) rd_next[15:0] = dst_lo_reg;
        else if (hit(i_araddr, dce_pkg::DST_HI_OFS)) rd_next[15:0] = dst_hi_reg;
        else if (hit(i_araddr, dce_pkg::INTP_OFS)) rd_next[15:0] = intp_reg;
        else if (hit(i_araddr, dce_pkg::LEN_OFS)) rd_next[15:0] = len_reg;
        else if (hit(i_araddr, dce_pkg::CTRL_OFS)) rd_next[15:0] = ctrl_reg;
        else rd_hit = 1'b0;
    end

    // axi read channels
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= dce_pkg::RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_next;
            o_rresp <= rd_hit ? dce_pkg::RESP_OKAY : dce_pkg::RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // request edge capture; a new edge wins over consumption
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_prev_reg <= 1'b0;
            edge_pend_reg <= 1'b0;
        end else begin
            req_prev_reg <= i_periph_req;
            if (i_periph_req && !req_prev_reg) edge_pend_reg <= 1'b1;
            else if (consume || !c_wfr) edge_pend_reg <= 1'b0;
        end
    end

    // transfer sequencer
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= dce_pkg::ST_IDLE;
            idx_reg <= 16'h0000;
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_addr <= 32'h0000_0000;
            o_mem_width <= dce_pkg::W_BYTE;
            o_mem_wdata <= 32'h0000_0000;
            data_reg <= 32'h0000_0000;
        end else begin
            case (state_reg)
                dce_pkg::ST_IDLE: begin
                    idx_reg <= 16'h0000;
                    if (c_run) begin
                        state_reg <= c_wfr ? dce_pkg::ST_WAIT : dce_pkg::ST_READ;
                    end
                end
                dce_pkg::ST_WAIT: begin
                    if (!c_run) begin
                        state_reg <= dce_pkg::ST_IDLE;
                    end else if (trigger) begin
                        state_reg <= dce_pkg::ST_READ;
                    end
                end
                dce_pkg::ST_GAP: begin
                    state_reg <= c_run ? dce_pkg::ST_READ : dce_pkg::ST_IDLE;
                end
                dce_pkg::ST_READ: begin
                    if (!o_mem_req) begin
                        if (!c_run) begin
                            state_reg <= dce_pkg::ST_IDLE;
                        end else if (c_fill && idx_reg != 16'h0000) begin
                            state_reg <= dce_pkg::ST_WRITE;
                        end else begin
                            o_mem_req <= 1'b1;
                            o_mem_we <= 1'b0;
                            o_mem_addr <= c_fill ? {src_hi_reg, src_lo_reg} : src_addr;
                            o_mem_width <= c_width;
                        end
                    end else if (i_mem_ack) begin
                        o_mem_req <= 1'b0;
                        data_reg <= i_mem_rdata;
                        state_reg <= dce_pkg::ST_WRITE;
                    end
                end
                dce_pkg::ST_WRITE: begin
                    if (!o_mem_req) begin
                        o_mem_req <= 1'b1;
                        o_mem_we <= 1'b1;
                        o_mem_addr <= dst_addr;
                        o_mem_width <= c_width;
                        o_mem_wdata <= data_reg;
                    end else if (i_mem_ack) begin
                        o_mem_req <= 1'b0;
                        o_mem_we <= 1'b0;
                        if (last_item) begin
                            idx_reg <= 16'h0000;
                            state_reg <= relaunch ? dce_pkg::ST_WAIT : dce_pkg::ST_IDLE;
                        end else begin
                            idx_reg <= idx_reg + 16'h0001;
                            if (c_wfr) begin
                                state_reg <= dce_pkg::ST_WAIT;
                            end else if (c_yield) begin
                                state_reg <= dce_pkg::ST_GAP;
                            end else begin
                                state_reg <= dce_pkg::ST_READ;
                            end
                        end
                    end
                end
                default: begin
                    state_reg <= dce_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // interrupt pulse and bus hold
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
            o_bus_lock <= 1'b0;
        end else begin
            o_irq <= item_done && c_irq_en && (intp_reg == idx_reg);
            o_bus_lock <= (state_reg == dce_pkg::ST_READ || state_reg == dce_pkg::ST_WRITE)
                || (c_fill && state_reg != dce_pkg::ST_IDLE);
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    wire in_xfer = (state_reg == dce_pkg::ST_READ) || (state_reg == dce_pkg::ST_WRITE);

    a_irq_match: assert property (item_done && c_irq_en && intp_reg == idx_reg |=> o_irq)
        else $error("interrupt missed at matching index");
    a_irq_gate: assert property (o_irq |-> $past(c_irq_en) && $past(item_done))
        else $error("interrupt without enable or item");
    a_idx_clear: assert property (item_done && last_item |=> idx_reg == 16'h0000)
        else $error("index not cleared at end");
    a_idx_step: assert property (item_done && !last_item |=> idx_reg == $past(idx_reg) + 16'h0001)
        else $error("index did not advance");
    a_run_clear: assert property (clear_run && !do_write |=> !c_run && state_reg == dce_pkg::ST_IDLE)
        else $error("run bit not cleared at completion");
    a_circ_keep: assert property (item_done && last_item && relaunch && !do_write |=> c_run ##0 state_reg == dce_pkg::ST_WAIT)
        else $error("circular transfer did not restart");
    a_fill_once: assert property (o_mem_req && !o_mem_we && c_fill |-> idx_reg == 16'h0000)
        else $error("fill mode fetched source twice");
    a_yield_gap: assert property (item_done && !last_item && c_yield && !c_wfr |=> state_reg == dce_pkg::ST_GAP ##1 state_reg != dce_pkg::ST_GAP)
        else $error("yield gap not one cycle");
    a_block_hold: assert property (in_xfer ##1 in_xfer |-> o_bus_lock)
        else $error("bus released during blocking copy");
    a_fill_hold: assert property ((c_fill && state_reg != dce_pkg::ST_IDLE) ##1 c_fill |-> o_bus_lock)
        else $error("bus released during fill");
    a_wait_req: assert property (state_reg == dce_pkg::ST_WAIT && c_run && !trigger |=> state_reg == dce_pkg::ST_WAIT)
        else $error("started without request");
    a_src_addr: assert property (state_reg == dce_pkg::ST_READ && c_run
        && !o_mem_req && !c_fill |=> !o_mem_we && o_mem_addr == $past(src_addr))
        else $error("source address wrong");
    a_dst_addr: assert property (state_reg == dce_pkg::ST_WRITE && !o_mem_req |=>
        o_mem_we && o_mem_addr == $past(dst_addr))
        else $error("destination address wrong");

    c_full_copy: cover property (clear_run && len_reg == 16'h0003);
    c_fill_run: cover property (item_done && c_fill && idx_reg == 16'h0002);
    c_edge_wait: cover property (consume && c_sense);
    c_irq_fire: cover property (o_irq);
    c_yield_gap: cover property (state_reg == dce_pkg::ST_GAP);
endmodule // dce_channel

// [dce_mem_model.sv]
/*
 far-side model: byte memory on the system bus of the channel.
 assumes one request at a time, held by the channel until the one-cycle ack.
*/
`timescale 1ns/1ps
module dce_mem_model (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // system bus from the channel
    input wire logic i_mem_req,
    input wire logic i_mem_we,
    input wire logic [31:0] i_mem_addr,
    input wire logic [1:0] i_mem_width,
    input wire logic [31:0] i_mem_wdata,
    output logic o_mem_ack,
    output logic [31:0] o_mem_rdata,
    // answer speed
    input wire logic i_slow
);
    logic [7:0] mem [0:1023];
    logic [31:0] rd_q;
    logic [1:0] cnt;
    int nb;
    initial for (int i = 0; i < 1024; i++) mem[i] = 8'(i) ^ 8'h5a;
    // read data scrambled outside the ack cycle
    assign o_mem_rdata = o_mem_ack ? rd_q : ~rd_q;
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_ack <= 1'b0;
            cnt <= 2'h0;
            rd_q <= 32'h0000_0000;
        end else begin
            o_mem_ack <= 1'b0;
            if (i_mem_req && !o_mem_ack) begin
                if (cnt == (i_slow ? 2'h3 : 2'h0)) begin
                    o_mem_ack <= 1'b1;
                    cnt <= 2'h0;
                    nb = (i_mem_width == dce_pkg::W_HALF) ? 2 :
                        (i_mem_width == dce_pkg::W_WORD) ? 4 : 1;
                    for (int b = 0; b < 4; b++) begin
                        rd_q[8*b +: 8] <= mem[10'(i_mem_addr[9:0] + b)];
                        if (i_mem_we && b < nb)
                            mem[10'(i_mem_addr[9:0] + b)] <= i_mem_wdata[8*b +: 8];
                    end
                end else
                    cnt <= cnt + 2'h1;
            end
        end
    end
endmodule // dce_mem_model

// [tb_top.sv]
/*
 testbench for dce_channel: register access over axi4-lite and dma runs.
 assumes dce_mem_model as the system bus memory.
*/
`timescale 1ns/1ps
module tb_top;
    localparam logic [31:0] REGS [8] = '{dce_pkg::IDX_OFS, dce_pkg::SRC_LO_OFS,
        dce_pkg::SRC_HI_OFS, dce_pkg::DST_LO_OFS, dce_pkg::DST_HI_OFS,
        dce_pkg::INTP_OFS, dce_pkg::LEN_OFS, dce_pkg::CTRL_OFS};
    localparam logic [15:0] RUN = 16'h0001 << dce_pkg::CB_RUN;
    localparam logic [15:0] SST = 16'h0001 << dce_pkg::CB_SRC_STEP;
    localparam logic [15:0] DST = 16'h0001 << dce_pkg::CB_DST_STEP;
    localparam logic [15:0] WFR = 16'h0001 << dce_pkg::CB_WFR;
    localparam logic [15:0] IEN = 16'h0001 << dce_pkg::CB_IRQ_EN;
    localparam logic [15:0] CIR = 16'h0001 << dce_pkg::CB_CIRC;
    localparam logic [15:0] YLD = 16'h0001 << dce_pkg::CB_YIELD;
    localparam logic [15:0] FIL = 16'h0001 << dce_pkg::CB_FILL;
    localparam logic [15:0] SNS = 16'h0001 << dce_pkg::CB_SENSE;
    localparam logic [15:0] HALF = 16'(dce_pkg::W_HALF) << dce_pkg::CB_WIDTH_LO;
    localparam logic [15:0] WORD = 16'(dce_pkg::W_WORD) << dce_pkg::CB_WIDTH_LO;
    logic clk, rst_n, awv, wv, bry, arv, rry, preq, slow, prev_req;
    logic awr, wrdy, bv, arr, rv, mreq, mwe, mack, lock, irq;
    logic [15:0] awa, ara;
    logic [31:0] wd, rdd, maddr, mwd, mrd;
    logic [3:0] ws;
    logic [1:0] br, rr, mw, br_q;
    int num_errors = 0, n_compared = 0, cyc = 0, n_st = 0, n_ld = 0, n_irq = 0;
    int n_unlk = 0, n_hi = 0, st_cyc = 0, gap = 0, s0, l0, q0;
    dce_channel #(.AW(16)) uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_awaddr(awa),
        .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv),
        .o_wready(wrdy), .o_bresp(br), .o_bvalid(bv), .i_bready(bry), .i_araddr(ara),
        .i_arvalid(arv), .o_arready(arr), .o_rdata(rdd), .o_rresp(rr), .o_rvalid(rv),
        .i_rready(rry), .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_addr(maddr),
        .o_mem_width(mw), .o_mem_wdata(mwd), .i_mem_ack(mack), .i_mem_rdata(mrd),
        .o_bus_lock(lock), .i_periph_req(preq), .o_irq(irq));
    dce_mem_model u_mem (.i_core_clk(clk), .i_rst_n(rst_n), .i_mem_req(mreq),
        .i_mem_we(mwe), .i_mem_addr(maddr), .i_mem_width(mw), .i_mem_wdata(mwd),
        .o_mem_ack(mack), .o_mem_rdata(mrd), .i_slow(slow));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task automatic tally_and_finish;
        if (num_errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // bus monitor and timeout
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
        if (mreq === 1'b1 && mack === 1'b1) begin
            if (maddr[31:16] !== (mwe ? 16'h1238 : 16'h1236)) n_hi++;
            if (mwe === 1'b1) begin
                n_st++;
                st_cyc = cyc;
                if (lock !== 1'b1) n_unlk++;
            end else n_ld++;
        end
        if (mreq === 1'b1 && prev_req === 1'b0 && mwe === 1'b0) gap = cyc - st_cyc;
        if (irq === 1'b1) n_irq++;
        prev_req = mreq;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] ra(input logic [31:0] ofs);
        return {ofs[13:0], 2'b00};
    endfunction
    function automatic logic [31:0] pat(input int a);
        return {24'h00_0000, 8'(a) ^ 8'h5a};
    endfunction
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic ad, dd;
        ad = 0;
        dd = 0;
        @(posedge clk);
        awa <= a;
        awv <= 1;
        wd <= {16'h0000, d};
        ws <= 4'hf;
        wv <= 1;
        bry <= 1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (!ad && awr === 1'b1) begin
                ad = 1;
                awv <= 0;
            end
            if (!dd && wrdy === 1'b1) begin
                dd = 1;
                wv <= 0;
            end
        end
        do @(posedge clk); while (bv !== 1'b1);
        br_q = br;
        bry <= 0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        ara <= a;
        arv <= 1;
        rry <= 1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 0;
        do @(posedge clk); while (rv !== 1'b1);
        d = rdd;
        r = rr;
        rry <= 0;
    endtask
    task automatic rck(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic go(input logic [15:0] s, d, len, ip, c);
        wr(ra(dce_pkg::SRC_LO_OFS), s);
        wr(ra(dce_pkg::DST_LO_OFS), d);
        wr(ra(dce_pkg::LEN_OFS), len);
        wr(ra(dce_pkg::INTP_OFS), ip);
        s0 = n_st;
        l0 = n_ld;
        q0 = n_irq;
        wr(ra(dce_pkg::CTRL_OFS), c);
    endtask
    task automatic wait_done;
        logic [31:0] d;
        logic [1:0] r;
        d = 1;
        while (d[0] !== 1'b0) rd(ra(dce_pkg::CTRL_OFS), d, r);
    endtask
    task automatic mck(input int s, d, nb, wb, fill);
        for (int i = 0; i <= nb; i++)
            chk({24'h00_0000, u_mem.mem[d+i]}, (i == nb) ? pat(d + i) : pat(s + (fill ? i % wb : i)));
    endtask
    initial begin
        {rst_n, awv, wv, bry, arv, rry, preq, slow, prev_req} = 0;
        {awa, ara, wd, ws} = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1;
        foreach (REGS[i]) rck(ra(REGS[i]), 0, dce_pkg::RESP_OKAY);
        rck(16'h0004, 0, dce_pkg::RESP_SLVERR);
        for (int i = 1; i < 7; i++) wr(ra(REGS[i]), 16'h1234 + 16'(i));
        chk({30'h0, br_q}, {30'h0, dce_pkg::RESP_OKAY});
        wr(16'h0004, 16'h00ff);
        chk({30'h0, br_q}, {30'h0, dce_pkg::RESP_SLVERR});
        for (int i = 1; i < 7; i++) rck(ra(REGS[i]), 32'h1234 + i, 0);
        wr(ra(dce_pkg::IDX_OFS), 16'h00ff);
        chk({30'h0, br_q}, {30'h0, dce_pkg::RESP_OKAY});
        rck(ra(dce_pkg::IDX_OFS), 0, dce_pkg::RESP_OKAY);
        slow <= 1;
        go(16'h0010, 16'h0100, 3, 2, RUN | HALF | SST | DST | IEN);
        wait_done();
        chk(32'(n_st - s0), 4);
        chk(32'(n_irq - q0), 1);
        chk(32'(gap), 2);
        mck(16'h0010, 16'h0100, 8, 2, 0);
        rck(ra(dce_pkg::IDX_OFS), 0, dce_pkg::RESP_OKAY);
        slow <= 0;
        for (int k = 0; k < 2; k++) begin
            go(16'h0020, 16'h0140 + 16'(64 * k), 1, 0, RUN | SST | DST | (k ? WORD : 16'h0000));
            wait_done();
            chk(32'(n_irq - q0), 0);
            mck(16'h0020, 16'h0140 + 64 * k, k ? 8 : 2, k ? 4 : 1, 0);
        end
        go(16'h0030, 16'h01c0, 2, 9, RUN | SST | DST | YLD);
        wait_done();
        chk(32'(gap), 3);
        go(16'h0044, 16'h0200, 3, 9, RUN | FIL | SST | DST);
        wait_done();
        chk(32'(n_ld - l0), 1);
        mck(16'h0044, 16'h0200, 4, 1, 1);
        chk(32'(n_unlk), 0);
        go(16'h0050, 16'h0240, 1, 9, RUN | WFR | SST | DST | YLD);
        repeat (20) @(posedge clk);
        chk(32'(n_st - s0), 0);
        preq <= 1;
        wait_done();
        chk(32'(n_st - s0), 2);
        mck(16'h0050, 16'h0240, 2, 1, 0);
        preq <= 0;
        go(16'h0060, 16'h0280, 1, 9, RUN | WFR | SNS | SST | DST);
        preq <= 1;
        repeat (30) @(posedge clk);
        chk(32'(n_st - s0), 1);
        preq <= 0;
        repeat (3) @(posedge clk);
        preq <= 1;
        wait_done();
        chk(32'(n_st - s0), 2);
        go(16'h0070, 16'h02c0, 1, 9, RUN | WFR | CIR | SST | DST);
        while (n_st - s0 < 5) @(posedge clk);
        rck(ra(dce_pkg::CTRL_OFS), RUN | WFR | CIR | SST | DST, 0);
        preq <= 0;
        wr(ra(dce_pkg::CTRL_OFS), 16'h0000);
        repeat (10) @(posedge clk);
        rck(ra(dce_pkg::IDX_OFS), 0, dce_pkg::RESP_OKAY);
        chk(32'(n_hi), 0);
        tally_and_finish();
    end
endmodule // tb_top
